// ===== include/pdmac_pkg.sv
package pdmac_pkg;

  // register byte offsets
  localparam logic [7:0] PDMAC_OFF_RX_CUR_ADDR = 8'h00;
  localparam logic [7:0] PDMAC_OFF_RX_CUR_COUNT = 8'h04;
  localparam logic [7:0] PDMAC_OFF_TX_CUR_ADDR = 8'h08;
  localparam logic [7:0] PDMAC_OFF_TX_CUR_COUNT = 8'h0C;
  localparam logic [7:0] PDMAC_OFF_RX_NEXT_ADDR = 8'h10;
  localparam logic [7:0] PDMAC_OFF_RX_NEXT_COUNT = 8'h14;
  localparam logic [7:0] PDMAC_OFF_TX_NEXT_ADDR = 8'h18;
  localparam logic [7:0] PDMAC_OFF_TX_NEXT_COUNT = 8'h1C;
  localparam logic [7:0] PDMAC_OFF_CONTROL = 8'h20;
  localparam logic [7:0] PDMAC_OFF_STATE = 8'h24;

  // control and state bit positions
  localparam int PDMAC_BIT_RX_EN = 0;
  localparam int PDMAC_BIT_RX_DIS = 1;
  localparam int PDMAC_BIT_TX_EN = 8;
  localparam int PDMAC_BIT_TX_DIS = 9;

  // widths, reset values and the count decrement
  localparam int PDMAC_COUNT_W = 16;
  localparam int PDMAC_ADDR_W = 32;
  localparam logic [31:0] PDMAC_ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] PDMAC_ZERO_COUNT = 16'h0000;
  localparam logic [15:0] PDMAC_ONE_COUNT = 16'h0001;

  // storage index of each view
  localparam logic PDMAC_CH_RX = 1'b0;
  localparam logic PDMAC_CH_TX = 1'b1;

  // address increments per item
  localparam logic [31:0] PDMAC_STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] PDMAC_STEP_HALF = 32'h0000_0002;
  localparam logic [31:0] PDMAC_STEP_WORD = 32'h0000_0004;

  // ahb-lite codes
  localparam logic [1:0] PDMAC_HTRANS_NONSEQ = 2'h2;
  localparam logic PDMAC_HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    PDMAC_SIZE_BYTE,
    PDMAC_SIZE_HALF,
    PDMAC_SIZE_WORD
  } pdmac_size_type;

  // memory port request
  typedef struct packed {
    logic req;
    logic write;
    pdmac_size_type size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pdmac_mem_req_type;

  // flags returned to the peripheral
  typedef struct packed {
    logic rx_end_flag;
    logic rx_full_flag;
    logic tx_end_flag;
    logic tx_empty_flag;
  } pdmac_flags_type;

endpackage

// ===== core/pdmac_channel.sv
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

module pdmac_channel #(
  parameter bit HALF_DUPLEX = 1'b0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // serial peripheral
  input wire logic rx_ready,
  input wire logic [31:0] rx_holding_reg,
  output logic rx_take,
  input wire logic tx_ready,
  output logic [31:0] tx_holding_reg,
  output logic tx_load,
  input wire pdmac_pkg::pdmac_size_type xfer_size,
  output pdmac_pkg::pdmac_flags_type flags,
  // memory port
  output pdmac_pkg::pdmac_mem_req_type mem_out,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  import pdmac_pkg::*;

  typedef enum logic [1:0] {
    PDMAC_ENG_IDLE,
    PDMAC_ENG_RX_WR,
    PDMAC_ENG_TX_RD
  } pdmac_eng_type;

  // shared storage index of a view
  function automatic logic sidx(input logic view);
    sidx = HALF_DUPLEX ? PDMAC_CH_RX : view;
  endfunction

  // address increment for a transfer size
  function automatic logic [31:0] step_of(input pdmac_size_type sz);
    case (sz)
      PDMAC_SIZE_BYTE: step_of = PDMAC_STEP_BYTE;
      PDMAC_SIZE_HALF: step_of = PDMAC_STEP_HALF;
      default: step_of = PDMAC_STEP_WORD;
    endcase
  endfunction

  // register state
  logic [31:0] cur_addr [2];
  logic [15:0] cur_count [2];
  logic [31:0] nxt_addr [2];
  logic [15:0] nxt_count [2];
  logic [1:0] end_flag;
  logic [1:0] buf_flag;
  logic rx_en;
  logic tx_en;
  // bus state
  logic wr_pend;
  logic rd_wait;
  logic [7:0] ap_addr;
  // engine state
  pdmac_eng_type eng;
  logic [31:0] rx_buffer;
  logic [31:0] eng_addr;

  logic [31:0] next_cur_addr [2];
  logic [15:0] next_cur_count [2];
  logic [31:0] next_nxt_addr [2];
  logic [15:0] next_nxt_count [2];
  logic [1:0] next_end_flag;
  logic [1:0] next_buf_flag;
  logic next_rx_en;
  logic next_tx_en;
  logic next_wr_pend;
  logic next_rd_wait;
  logic [7:0] next_ap_addr;
  logic [31:0] next_hrdata;
  pdmac_eng_type next_eng;
  logic [31:0] next_rx_buffer;
  logic [31:0] next_eng_addr;
  logic [31:0] next_tx_holding;
  logic next_tx_load;
  logic next_rx_take;

  logic ap_valid;
  logic rx_active;
  logic tx_active;
  logic done_ch;
  logic [15:0] dec_count;
  logic [31:0] wd;
  logic we_ctl;

  assign ap_valid = hsel && hready && (htrans == PDMAC_HTRANS_NONSEQ);
  assign rx_active = rx_en && (cur_count[sidx(PDMAC_CH_RX)] != PDMAC_ZERO_COUNT);
  assign tx_active = tx_en && (cur_count[sidx(PDMAC_CH_TX)] != PDMAC_ZERO_COUNT);
  assign hreadyout = !rd_wait;
  assign hresp = PDMAC_HRESP_OKAY;
  assign wd = hwdata;
  assign we_ctl = wr_pend && (ap_addr == PDMAC_OFF_CONTROL);
  assign done_ch = (eng == PDMAC_ENG_RX_WR) ? sidx(PDMAC_CH_RX) : sidx(PDMAC_CH_TX);
  assign dec_count = cur_count[done_ch] - PDMAC_ONE_COUNT;

  // register read decode
  function automatic logic [31:0] read_reg(input logic [7:0] a);
    case (a)
      PDMAC_OFF_RX_CUR_ADDR: read_reg = cur_addr[sidx(PDMAC_CH_RX)];
      PDMAC_OFF_RX_CUR_COUNT: read_reg = {16'h0000, cur_count[sidx(PDMAC_CH_RX)]};
      PDMAC_OFF_TX_CUR_ADDR: read_reg = cur_addr[sidx(PDMAC_CH_TX)];
      PDMAC_OFF_TX_CUR_COUNT: read_reg = {16'h0000, cur_count[sidx(PDMAC_CH_TX)]};
      PDMAC_OFF_RX_NEXT_ADDR: read_reg = nxt_addr[sidx(PDMAC_CH_RX)];
      PDMAC_OFF_RX_NEXT_COUNT: read_reg = {16'h0000, nxt_count[sidx(PDMAC_CH_RX)]};
      PDMAC_OFF_TX_NEXT_ADDR: read_reg = nxt_addr[sidx(PDMAC_CH_TX)];
      PDMAC_OFF_TX_NEXT_COUNT: read_reg = {16'h0000, nxt_count[sidx(PDMAC_CH_TX)]};
      PDMAC_OFF_STATE: begin
        read_reg = PDMAC_ZERO_WORD;
        read_reg[PDMAC_BIT_RX_EN] = rx_en;
        read_reg[PDMAC_BIT_TX_EN] = tx_en;
      end
      default: read_reg = PDMAC_ZERO_WORD;
    endcase
  endfunction

  always_comb begin
    next_cur_addr = cur_addr;
    next_cur_count = cur_count;
    next_nxt_addr = nxt_addr;
    next_nxt_count = nxt_count;
    next_end_flag = end_flag;
    next_buf_flag = buf_flag;
    next_rx_en = rx_en;
    next_tx_en = tx_en;
    next_eng = eng;
    next_rx_buffer = rx_buffer;
    next_eng_addr = eng_addr;
    next_tx_holding = tx_holding_reg;
    next_tx_load = 1'b0;
    next_rx_take = 1'b0;
    next_hrdata = hrdata;
    // bus phases: writes take no wait, reads one wait state
    next_wr_pend = ap_valid && hwrite;
    next_rd_wait = ap_valid && !hwrite;
    next_ap_addr = ap_valid ? haddr[7:0] : ap_addr;
    if (rd_wait) begin
      next_hrdata = read_reg(ap_addr);
    end

    // engine: one item at a time, receive first
    case (eng)
      PDMAC_ENG_IDLE: begin
        if (rx_active && rx_ready) begin
          next_rx_buffer = rx_holding_reg;
          next_rx_take = 1'b1;
          next_eng_addr = cur_addr[sidx(PDMAC_CH_RX)];
          next_eng = PDMAC_ENG_RX_WR;
        end else if (tx_active && tx_ready) begin
          next_eng_addr = cur_addr[sidx(PDMAC_CH_TX)];
          next_eng = PDMAC_ENG_TX_RD;
        end
      end
      PDMAC_ENG_RX_WR, PDMAC_ENG_TX_RD: begin
        if (mem_ack) begin
          next_eng = PDMAC_ENG_IDLE;
          if (eng == PDMAC_ENG_TX_RD) begin
            next_tx_holding = mem_rdata;
            next_tx_load = 1'b1;
          end
          next_cur_addr[done_ch] = cur_addr[done_ch] + step_of(xfer_size);
          next_cur_count[done_ch] = dec_count;
          if (dec_count == PDMAC_ZERO_COUNT) begin
            if (nxt_count[done_ch] != PDMAC_ZERO_COUNT) begin
              next_cur_addr[done_ch] = nxt_addr[done_ch];
              next_cur_count[done_ch] = nxt_count[done_ch];
              next_nxt_addr[done_ch] = PDMAC_ZERO_WORD;
              next_nxt_count[done_ch] = PDMAC_ZERO_COUNT;
            end
          end
        end
      end
      default: next_eng = PDMAC_ENG_IDLE;
    endcase

    // software writes win over the engine on the same storage
    if (wr_pend) begin
      case (ap_addr)
        PDMAC_OFF_RX_CUR_ADDR: next_cur_addr[sidx(PDMAC_CH_RX)] = wd;
        PDMAC_OFF_TX_CUR_ADDR: next_cur_addr[sidx(PDMAC_CH_TX)] = wd;
        PDMAC_OFF_RX_CUR_COUNT: next_cur_count[sidx(PDMAC_CH_RX)] = wd[PDMAC_COUNT_W-1:0];
        PDMAC_OFF_TX_CUR_COUNT: next_cur_count[sidx(PDMAC_CH_TX)] = wd[PDMAC_COUNT_W-1:0];
        PDMAC_OFF_RX_NEXT_ADDR: next_nxt_addr[sidx(PDMAC_CH_RX)] = wd;
        PDMAC_OFF_TX_NEXT_ADDR: next_nxt_addr[sidx(PDMAC_CH_TX)] = wd;
        PDMAC_OFF_RX_NEXT_COUNT: next_nxt_count[sidx(PDMAC_CH_RX)] = wd[PDMAC_COUNT_W-1:0];
        PDMAC_OFF_TX_NEXT_COUNT: next_nxt_count[sidx(PDMAC_CH_TX)] = wd[PDMAC_COUNT_W-1:0];
        default: begin
        end
      endcase
      // nonzero count write clears that channel's flags
      if (wd[PDMAC_COUNT_W-1:0] != PDMAC_ZERO_COUNT) begin
        if (ap_addr == PDMAC_OFF_RX_CUR_COUNT || ap_addr == PDMAC_OFF_RX_NEXT_COUNT) begin
          next_end_flag[sidx(PDMAC_CH_RX)] = 1'b0;
          next_buf_flag[sidx(PDMAC_CH_RX)] = 1'b0;
        end
        if (ap_addr == PDMAC_OFF_TX_CUR_COUNT || ap_addr == PDMAC_OFF_TX_NEXT_COUNT) begin
          next_end_flag[sidx(PDMAC_CH_TX)] = 1'b0;
          next_buf_flag[sidx(PDMAC_CH_TX)] = 1'b0;
        end
      end
    end

    // flag set after clear so a same-cycle event is kept
    if (eng != PDMAC_ENG_IDLE && mem_ack && dec_count == PDMAC_ZERO_COUNT) begin
      next_end_flag[done_ch] = 1'b1;
      if (nxt_count[done_ch] == PDMAC_ZERO_COUNT) begin
        next_buf_flag[done_ch] = 1'b1;
      end
    end

    // control register: zero bits do nothing
    if (we_ctl) begin
      if (wd[PDMAC_BIT_RX_EN] && !wd[PDMAC_BIT_RX_DIS]) begin
        next_rx_en = 1'b1;
        if (HALF_DUPLEX) begin
          next_tx_en = 1'b0;
        end
      end
      if (wd[PDMAC_BIT_TX_EN] && !(HALF_DUPLEX && wd[PDMAC_BIT_RX_EN])) begin
        next_tx_en = 1'b1;
      end
      if (wd[PDMAC_BIT_RX_DIS]) begin
        next_rx_en = 1'b0;
        if (HALF_DUPLEX) begin
          next_tx_en = 1'b0;
        end
      end
      if (wd[PDMAC_BIT_TX_DIS]) begin
        next_tx_en = 1'b0;
        if (HALF_DUPLEX) begin
          next_rx_en = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        cur_addr[i] <= PDMAC_ZERO_WORD;
        cur_count[i] <= PDMAC_ZERO_COUNT;
        nxt_addr[i] <= PDMAC_ZERO_WORD;
        nxt_count[i] <= PDMAC_ZERO_COUNT;
      end
      end_flag <= 2'h0;
      buf_flag <= 2'h0;
      rx_en <= 1'b0;
      tx_en <= 1'b0;
      wr_pend <= 1'b0;
      rd_wait <= 1'b0;
      ap_addr <= 8'h00;
      hrdata <= PDMAC_ZERO_WORD;
      eng <= PDMAC_ENG_IDLE;
      rx_buffer <= PDMAC_ZERO_WORD;
      eng_addr <= PDMAC_ZERO_WORD;
      tx_holding_reg <= PDMAC_ZERO_WORD;
      tx_load <= 1'b0;
      rx_take <= 1'b0;
    end else begin
      cur_addr <= next_cur_addr;
      cur_count <= next_cur_count;
      nxt_addr <= next_nxt_addr;
      nxt_count <= next_nxt_count;
      end_flag <= next_end_flag;
      buf_flag <= next_buf_flag;
      rx_en <= next_rx_en;
      tx_en <= next_tx_en;
      wr_pend <= next_wr_pend;
      rd_wait <= next_rd_wait;
      ap_addr <= next_ap_addr;
      hrdata <= next_hrdata;
      eng <= next_eng;
      rx_buffer <= next_rx_buffer;
      eng_addr <= next_eng_addr;
      tx_holding_reg <= next_tx_holding;
      tx_load <= next_tx_load;
      rx_take <= next_rx_take;
    end
  end

  // memory request, address and data stand from state flops until acknowledged; size follows xfer_size
  always_comb begin
    mem_out.req = (eng != PDMAC_ENG_IDLE);
    mem_out.write = (eng == PDMAC_ENG_RX_WR);
    mem_out.size = xfer_size;
    mem_out.addr = eng_addr;
    mem_out.wdata = rx_buffer;
  end

  always_comb begin
    flags.rx_end_flag = end_flag[sidx(PDMAC_CH_RX)];
    flags.rx_full_flag = buf_flag[sidx(PDMAC_CH_RX)];
    flags.tx_end_flag = end_flag[sidx(PDMAC_CH_TX)];
    flags.tx_empty_flag = buf_flag[sidx(PDMAC_CH_TX)];
  end

endmodule

`default_nettype wire

// ===== sim/pdmac_channel_properties.sv
`timescale 1ns/1ns
`default_nettype none
module pdmac_channel_properties (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // peripheral and memory
  input wire logic rx_ready,
  input wire logic rx_take,
  input wire logic tx_ready,
  input wire pdmac_pkg::pdmac_flags_type flags,
  input wire pdmac_pkg::pdmac_mem_req_type mem_out,
  input wire logic mem_ack
);
  import pdmac_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence wr_at(logic [7:0] off);
    hsel && hready && htrans == PDMAC_HTRANS_NONSEQ && hwrite && haddr[7:0] == off;
  endsequence
  sequence tx_start;
    $rose(mem_out.req) && !mem_out.write;
  endsequence
  a_rx_needs_ready: assert property (rx_take |-> $past(rx_ready))
    else $error("receive item taken without ready");
  a_tx_needs_ready: assert property (tx_start |-> $past(tx_ready))
    else $error("transmit fetch without ready");
  a_rx_dis_stops: assert property (wr_at(PDMAC_OFF_CONTROL) ##1 (hready && hwdata[PDMAC_BIT_RX_DIS])
    |-> ##2 (!rx_take) [*2]) else $error("receive started after disable");
  a_tx_dis_stops: assert property (wr_at(PDMAC_OFF_CONTROL) ##1 (hready && hwdata[PDMAC_BIT_TX_DIS])
    |-> ##2 (!tx_start) [*2]) else $error("transmit started after disable");
  a_end_after_ack: assert property ($rose(flags.rx_end_flag) |-> $past(mem_out.req && mem_out.write && mem_ack))
    else $error("receive end flag without last write");
  a_empty_with_end: assert property ($rose(flags.tx_empty_flag) |-> flags.tx_end_flag)
    else $error("empty flag without end flag");
  a_flag_clear: assert property (wr_at(PDMAC_OFF_RX_NEXT_COUNT) ##1 (hwdata[15:0] != 16'h0000 && !mem_ack)
    |=> !flags.rx_end_flag && !flags.rx_full_flag) else $error("receive flags not cleared");
  a_req_held: assert property (mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out.addr))
    else $error("memory request dropped before ack");
endmodule
bind pdmac_channel pdmac_channel_properties u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .rx_ready, .rx_take, .tx_ready, .flags, .mem_out, .mem_ack);
`default_nettype wire

// ===== sim/pdmac_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module pdmac_far_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // scenario controls
  input wire logic rx_go,
  input wire logic tx_go,
  input wire logic slow,
  // peripheral side
  input wire logic rx_take,
  output logic rx_ready,
  output logic [31:0] rx_holding_reg,
  output logic tx_ready,
  // memory side
  input wire pdmac_pkg::pdmac_mem_req_type mem_out,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  import pdmac_pkg::*;
  logic [3:0] wait_n, next_wait_n;
  logic [7:0] cyc;
  logic next_ack, next_rx_ready;
  always_comb begin
    next_ack = mem_out.req && !mem_ack && wait_n >= (slow ? 4'h3 : 4'h0);
    next_wait_n = (mem_out.req && !mem_ack) ? wait_n + 4'h1 : 4'h0;
    next_rx_ready = rx_go && !rx_take;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_n <= 4'h0;
      mem_ack <= 1'b0;
      rx_ready <= 1'b0;
      rx_holding_reg <= 32'h0;
      cyc <= 8'h0;
    end else begin
      wait_n <= next_wait_n;
      mem_ack <= next_ack;
      rx_ready <= next_rx_ready;
      rx_holding_reg <= rx_take ? rx_holding_reg + 32'h1111 : rx_holding_reg;
      cyc <= cyc + 8'h1;
    end
  end
  assign tx_ready = tx_go;
  // read data only valid with ack; otherwise a moving pattern
  assign mem_rdata = mem_ack ? ~mem_out.addr : {4{cyc}};
endmodule
`default_nettype wire

// ===== sim/tb_peripheral_dma_channel_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tb_peripheral_dma_channel_regs;
  import pdmac_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
  logic rx_go = 1'b0, tx_go = 1'b0, slow = 1'b0, hsel_h = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic hreadyout, hresp, rx_ready, rx_take, tx_ready, tx_load, mem_ack;
  logic [31:0] hrdata, rx_holding_reg, tx_holding_reg, mem_rdata, hrdata_h;
  pdmac_size_type xfer_size = PDMAC_SIZE_BYTE;
  pdmac_flags_type flags;
  pdmac_mem_req_type mem_out;
  logic [31:0] exp_q[$], rxa_q[$], txd_q[$], rxw_q[$], exph_q[$];
  logic [15:0] ctl_tab[6] = '{16'h0003, 16'h0101, 16'h0000, 16'h0200, 16'h0302, 16'h0100};
  logic [15:0] st_tab[6] = '{16'h0000, 16'h0101, 16'h0101, 16'h0001, 16'h0000, 16'h0100};
  // half duplex control sequence, never both enable bits in one write
  logic [15:0] hc_tab[8] = '{16'h0001, 16'h0100, 16'h0001, 16'h0100, 16'h0002, 16'h0100, 16'h0001, 16'h0200};
  logic [15:0] hs_tab[8] = '{16'h0001, 16'h0101, 16'h0001, 16'h0101, 16'h0000, 16'h0100, 16'h0001, 16'h0000};
  logic [15:0] fs_tab[8] = '{16'h0001, 16'h0101, 16'h0101, 16'h0101, 16'h0100, 16'h0100, 16'h0101, 16'h0001};
  int n_fail = 0, cmp_count = 0, cyc_n = 0;
  always #5 hclk = ~hclk;
  pdmac_channel #(.HALF_DUPLEX(1'b0)) DUT (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rx_ready, .rx_holding_reg,
    .rx_take, .tx_ready, .tx_holding_reg, .tx_load, .xfer_size, .flags, .mem_out, .mem_ack, .mem_rdata);
  pdmac_far_model u_far (.hclk, .hresetn, .rx_go, .tx_go, .slow, .rx_take, .rx_ready, .rx_holding_reg,
    .tx_ready, .mem_out, .mem_ack, .mem_rdata);
  // half duplex register views, selected only in its own scenario
  pdmac_channel #(.HALF_DUPLEX(1'b1)) DUT_HD (.hclk, .hresetn, .hsel(hsel_h), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout(), .hrdata(hrdata_h), .hresp(), .rx_ready(1'b0),
    .rx_holding_reg(32'h0), .rx_take(), .tx_ready(1'b0), .tx_holding_reg(), .tx_load(), .xfer_size, .flags(),
    .mem_out(), .mem_ack(1'b0), .mem_rdata(32'h0));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one single transfer; a read notes its expected data
  task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] d);
    @(posedge hclk);
    htrans <= PDMAC_HTRANS_NONSEQ;
    haddr <= {24'h0, off};
    hwrite <= wr;
    if (!wr) exp_q.push_back(d);
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= wr ? d : ~d;
    do @(posedge hclk); while (!hreadyout);
  endtask
  always @(posedge hclk) begin
    if (rd_dp && hreadyout) check(hrdata, exp_q.pop_front());
    if (rd_dp && hreadyout && hsel_h) check(hrdata_h, exph_q.pop_front());
    if (hreadyout) rd_dp = htrans == PDMAC_HTRANS_NONSEQ && !hwrite;
    if (mem_out.req && mem_ack && mem_out.write) check(mem_out.addr, rxa_q.pop_front());
    if (mem_out.req && mem_ack && mem_out.write) check(mem_out.wdata, rxw_q.pop_front());
    if (tx_load) check(tx_holding_reg, txd_q.pop_front());
  end
  always @(posedge hclk) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    logic [31:0] a, b, r, dv;
    logic [15:0] n, m;
    logic [7:0] o;
    int k;
    void'($urandom(32'h3B3149AE));
    dv = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 11; i++) bus(1'b0, 8'(i * 4), 32'h0);
    r = $urandom;
    bus(1'b1, PDMAC_OFF_RX_NEXT_ADDR, r);
    bus(1'b0, PDMAC_OFF_RX_NEXT_ADDR, r);
    bus(1'b1, PDMAC_OFF_TX_NEXT_COUNT, ~r);
    bus(1'b0, PDMAC_OFF_TX_NEXT_COUNT, {16'h0, ~r[15:0]});
    bus(1'b1, PDMAC_OFF_STATE, 32'hFFFF_FFFF);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, PDMAC_OFF_CONTROL, {16'h0, ctl_tab[i]});
      bus(1'b0, PDMAC_OFF_STATE, {16'h0, st_tab[i]});
    end
    rx_go <= 1'b1;
    tx_go <= 1'b1;
    for (int c = 0; c < 2; c++) for (int s = 0; s < 3; s++) begin
      o = 8'(c * 8);
      xfer_size <= pdmac_size_type'(s);
      slow <= 1'($urandom);
      a = $urandom;
      b = $urandom;
      n = 16'($urandom_range(1, 4));
      m = 16'($urandom_range(1, 3));
      for (int i = 0; i < n + m; i++) begin
        r = i < n ? a + 32'(i << s) : b + 32'((i - n) << s);
        if (c == 0) begin
          rxa_q.push_back(r);
          rxw_q.push_back(dv);
          dv = dv + 32'h1111;
        end else begin
          txd_q.push_back(~r);
        end
      end
      bus(1'b1, PDMAC_OFF_RX_NEXT_ADDR + o, b);
      bus(1'b1, PDMAC_OFF_RX_NEXT_COUNT + o, {16'h0, m});
      bus(1'b1, PDMAC_OFF_RX_CUR_ADDR + o, a);
      bus(1'b1, PDMAC_OFF_CONTROL, c ? 32'h100 : 32'h1);
      bus(1'b1, PDMAC_OFF_RX_CUR_COUNT + o, {16'h0, n});
      @(posedge hclk);
      k = 0;
      while (!(c ? flags.tx_empty_flag : flags.rx_full_flag) && k < 400) begin
        @(posedge hclk);
        k++;
      end
      check(32'(k < 400), 32'h1);
      check({30'h0, c ? flags[1:0] : flags[3:2]}, 32'h3);
      bus(1'b0, PDMAC_OFF_RX_CUR_COUNT + o, 32'h0);
      bus(1'b0, PDMAC_OFF_RX_NEXT_COUNT + o, 32'h0);
      bus(1'b0, PDMAC_OFF_RX_NEXT_ADDR + o, 32'h0);
      bus(1'b0, PDMAC_OFF_RX_CUR_ADDR + o, b + (32'(m) << s));
      bus(1'b1, PDMAC_OFF_RX_CUR_COUNT + o, 32'h0);
      @(posedge hclk);
      check({30'h0, c ? flags[1:0] : flags[3:2]}, 32'h3);
      bus(1'b1, PDMAC_OFF_RX_NEXT_COUNT + o, 32'h5);
      @(posedge hclk);
      check({30'h0, c ? flags[1:0] : flags[3:2]}, 32'h0);
      bus(1'b1, PDMAC_OFF_CONTROL, 32'h0202);
    end
    // half duplex: shared storage and coupled enables
    rx_go <= 1'b0;
    tx_go <= 1'b0;
    hsel_h <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      o = 8'(j * 16);
      a = $urandom;
      b = $urandom;
      bus(1'b1, PDMAC_OFF_RX_CUR_ADDR + o, a);
      bus(1'b1, PDMAC_OFF_TX_CUR_ADDR + o, b);
      bus(1'b1, PDMAC_OFF_RX_CUR_COUNT + o, ~a);
      bus(1'b1, PDMAC_OFF_TX_CUR_COUNT + o, ~b);
      exph_q.push_back(b);
      bus(1'b0, PDMAC_OFF_RX_CUR_ADDR + o, a);
      exph_q.push_back({16'h0, ~b[15:0]});
      bus(1'b0, PDMAC_OFF_RX_CUR_COUNT + o, {16'h0, ~a[15:0]});
    end
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, PDMAC_OFF_CONTROL, {16'h0, hc_tab[i]});
      exph_q.push_back({16'h0, hs_tab[i]});
      bus(1'b0, PDMAC_OFF_STATE, {16'h0, fs_tab[i]});
    end
    repeat (10) @(posedge hclk);
    give_verdict();
  end
endmodule
`default_nettype wire
